// ### drtpr_regs.vh
// Register map, field positions and reset values of the debug directory
`ifndef DRTPR_REGS_VH
`define DRTPR_REGS_VH
// ============================================================
// Offsets (byte addresses)
`define DRTPR_ENTRY_BASE 12'h000
`define DRTPR_ENTRY_LAST 12'h7fc
`define DRTPR_PCR_BASE 12'hb00
`define DRTPR_PSR_BASE 12'hb80
`define DRTPR_FEAT_OFF 12'hc00
// ============================================================
// Feature register fields
`define DRTPR_FEAT_SYSTEM_RESET_REQ_PRESENT_BIT 5
`define DRTPR_FEAT_DEBUG_RESET_REQ_PRESENT_BIT 4
`define DRTPR_FEAT_VER_NONE 4'h0
`define DRTPR_FEAT_VER_V0 4'h1
// ============================================================
// Entry fields
`define DRTPR_ENT_OFS_LSB 12
`define DRTPR_ENT_DOM_MSB 8
`define DRTPR_ENT_DOM_LSB 4
`define DRTPR_ENT_DVALID_BIT 2
`define DRTPR_PRES_FINAL 2'h0
`define DRTPR_PRES_SKIP 2'h2
`define DRTPR_PRES_YES 2'h3
// ============================================================
// Power control and status fields
`define DRTPR_PCR_REQ_BIT 1
`define DRTPR_PCR_IMPL_BIT 0
`define DRTPR_PS_OFF 2'h0
`define DRTPR_PS_ON 2'h1
`define DRTPR_PS_HELD 2'h3
`define DRTPR_RST_REQ 1'h0
`define DRTPR_RST_PS 2'h0
`endif

// ### drtpr_sync.v
// Two-flop synchroniser for a vector of pin levels
`timescale 1ns/100ps
module drtpr_sync #(
	parameter W = 32
) (
	input wire clock,
	input wire rst,
	input wire ce,
	input wire [W-1:0] async_in,
	output reg [W-1:0] sync_out
);
	reg [W-1:0] meta_q;
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			meta_q <= {W{1'b0}};
			sync_out <= {W{1'b0}};
		end else if (ce) begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

// ### drtpr_domain.v
// Four-phase power handshake for one system power domain
`timescale 1ns/100ps
`include "drtpr_regs.vh"
module drtpr_domain #(
	parameter IMPL = 1'b1,
	parameter HELD_MODE = 1'b1
) (
	input wire clock,
	input wire rst,
	input wire ce,
	input wire req_wr,
	input wire req_val,
	input wire allow,
	input wire pwr_ok,
	output reg req_q,
	output reg [1:0] state_q,
	output reg pwr_req
);
	localparam S_OFF = 2'h0;
	localparam S_ON = 2'h1;
	localparam S_HELD = 2'h3;
	reg req_d;
	reg [1:0] state_d;
	always @* begin
		req_d = req_q;
		if (req_wr && IMPL) begin
			req_d = req_val; // [RULE15] [RULE24]
		end
		state_d = state_q;
		case (state_q)
			S_OFF: begin
				// Stays off while power cannot be raised
				if (req_q && allow && pwr_ok) begin // [RULE21]
					state_d = HELD_MODE ? S_HELD : S_ON; // [RULE19] [RULE20]
				end
			end
			S_ON: begin
				if (!req_q || !pwr_ok) begin
					state_d = S_OFF;
				end
			end
			S_HELD: begin
				// Held until request withdrawn, whatever the supply says
				if (!req_q) begin
					state_d = S_OFF; // [RULE20]
				end
			end
			default: state_d = S_OFF;
		endcase
		if (!IMPL) begin
			state_d = S_OFF; // [RULE24]
		end
	end
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			req_q <= `DRTPR_RST_REQ;
			state_q <= `DRTPR_RST_PS;
			pwr_req <= 1'b0;
		end else if (ce) begin
			req_q <= req_d;
			state_q <= state_d;
			// Keep power asked while request stands and debug is allowed, or held
			pwr_req <= (req_d && allow) || (state_d == S_HELD); // [RULE23]
		end
	end
endmodule

// ### drtpr_top.v
// Debug component directory with per-domain power request registers
// Behaviour
// [RULE1] Feature bit 5 reads 1 only when system reset request exists.
// [RULE2] Feature bit 4 reads 1 only when debug reset request exists.
// [RULE3] Feature version field reads 0 without power requests, 1 with them.
// [RULE4] Up to 512 read-only 32-bit entries at offset n times 4.
// [RULE5] Entry after the last component carries presence code zero.
// [RULE6] Entry at 0x7fc holds code 0 or 3 and is always final.
// [RULE7] Entry bits 31:12 are a signed offset, shifted by 12 bits.
// [RULE8] Multi-block components point at their identification block.
// [RULE9] A present entry never carries a zero offset.
// [RULE10] Domain number in bits 8:4 reads zero unless bit 2 is set.
// [RULE11] Presence codes: 0 final, 1 reserved, 2 skip, 3 present.
// [RULE12] Final entry has every other field zero.
// [RULE13] Without domain numbers all components share the directory domain.
// [RULE14] Up to 32 domain control registers at 0xb00 plus n times 4.
// [RULE15] Control bit 1 requests power; reserved when not implemented.
// [RULE16] Control bit 0 is read-only and shows request support.
// [RULE17] Requests may be ignored while debug is disabled.
// [RULE18] Status reads 0 maybe off, 1 powered, 3 powered and held.
// [RULE19] Only one of the two powered codes need be supported.
// [RULE20] Request set, status 3, request cleared, status 0.
// [RULE21] Status stays 0 if the domain cannot be powered.
// [RULE22] Debugger must not request again while status still reads 3.
// [RULE23] Plain powered domain keeps power while request stands.
// [RULE24] Unimplemented domains read request and status zero, ignore writes.
//
// The plain strobed port was decided locally.
`timescale 1ns/100ps
`include "drtpr_regs.vh"
module drtpr_top #(
	parameter NUM_ENTRIES = 512,
	parameter NUM_DOMAINS = 32,
	parameter [31:0] DOMAIN_IMPL = 32'hffffffff,
	parameter HELD_MODE = 1'b1,
	parameter SYS_RESET_PRESENT = 1'b0,
	parameter DBG_RESET_PRESENT = 1'b0,
	parameter NUM_COMPONENTS = 2,
	parameter [31:0] COMP_OFS0 = 32'h00001000,
	parameter [31:0] COMP_OFS1 = 32'hfffff000,
	parameter [4:0] COMP_DOM0 = 5'h00,
	parameter [4:0] COMP_DOM1 = 5'h01,
	parameter COMP_DOM_VALID = 1'b1
) (
	input wire clock,
	input wire rst,
	input wire ce,
	input wire [11:0] addr,
	input wire [31:0] wdata,
	input wire wr,
	input wire rd,
	output reg [31:0] rdata,
	input wire [31:0] pwr_ok_pin,
	input wire dbg_enable_pin,
	output reg [31:0] pwr_req
);
	// ============================================================
	// Entry table
	// Entries are constants built from parameters; a generic
	// directory could load them from a ROM instead.
	wire [31:0] entry_mem [0:NUM_ENTRIES-1];
	function [31:0] make_entry;
		input [31:0] ofs;
		input [4:0] dom;
		input dvalid;
		begin
			make_entry = {ofs[31:12], 3'h0, // [RULE7] [RULE8]
				dvalid ? dom : 5'h00, 1'b0, dvalid, // [RULE10] [RULE13]
				// Zero offset would point back here: mark it skipped
				((ofs[31:12] != 20'h00000) ? `DRTPR_PRES_YES :
				`DRTPR_PRES_SKIP)}; // [RULE9] [RULE11]
		end
	endfunction
	genvar gi;
	generate
		for (gi = 0; gi < NUM_ENTRIES; gi = gi + 1) begin : g_ent
			if (gi == 0) begin : g_c0
				assign entry_mem[gi] = make_entry(COMP_OFS0, COMP_DOM0,
					COMP_DOM_VALID);
			end else if (gi == 1 && NUM_COMPONENTS > 1) begin : g_c1
				assign entry_mem[gi] = make_entry(COMP_OFS1, COMP_DOM1,
					COMP_DOM_VALID);
			end else begin : g_zero
				// Terminator and all beyond: every field zero
				assign entry_mem[gi] = 32'h00000000; // [RULE5] [RULE12]
			end
		end
	endgenerate
	// ============================================================
	// Decode helpers
	function is_entry;
		input [11:0] a;
		begin
			is_entry = (a <= `DRTPR_ENTRY_LAST) &&
				(a[11:2] < NUM_ENTRIES); // [RULE4]
		end
	endfunction
	function in_window;
		input [11:0] a;
		input [11:0] base;
		begin
			in_window = (a >= base) && (a < base + 12'h080) &&
				((a - base) >> 2 < NUM_DOMAINS); // [RULE14]
		end
	endfunction
	// ============================================================
	// Pin synchronisers
	wire [31:0] pwr_ok_s;
	wire dbg_en_s;
	drtpr_sync #(.W(32)) u_sync_ok (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.async_in(pwr_ok_pin),
		.sync_out(pwr_ok_s)
	);
	drtpr_sync #(.W(1)) u_sync_en (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.async_in(dbg_enable_pin),
		.sync_out(dbg_en_s)
	);
	// ============================================================
	// Power domains
	wire [31:0] dom_req;
	wire [63:0] dom_state;
	wire [31:0] dom_pwr;
	wire pcr_hit = wr && in_window(addr, `DRTPR_PCR_BASE);
	wire [4:0] dom_idx = addr[6:2];
	generate
		for (gi = 0; gi < 32; gi = gi + 1) begin : g_dom
			drtpr_domain #(
				.IMPL(DOMAIN_IMPL[gi] && (gi < NUM_DOMAINS)),
				.HELD_MODE(HELD_MODE)
			) u_dom (
				.clock(clock),
				.rst(rst),
				.ce(ce),
				.req_wr(pcr_hit && dom_idx == gi),
				.req_val(wdata[`DRTPR_PCR_REQ_BIT]),
				// Request bit still stored; no new power-up while debug is disabled
				.allow(dbg_en_s), // [RULE17]
				.pwr_ok(pwr_ok_s[gi]),
				.req_q(dom_req[gi]),
				.state_q(dom_state[2*gi+1:2*gi]),
				.pwr_req(dom_pwr[gi])
			);
		end
	endgenerate
	// ============================================================
	// Read mux
	wire any_impl = |(DOMAIN_IMPL & ((NUM_DOMAINS >= 32) ? 32'hffffffff :
		((32'h1 << NUM_DOMAINS) - 32'h1)));
	reg [31:0] rdata_d;
	always @* begin
		rdata_d = 32'h00000000;
		if (is_entry(addr)) begin
			rdata_d = entry_mem[addr[10:2]]; // [RULE4] [RULE9]
			if (addr == `DRTPR_ENTRY_LAST &&
				rdata_d[1:0] != `DRTPR_PRES_YES) begin
				rdata_d = 32'h00000000; // [RULE6]
			end
		end else if (in_window(addr, `DRTPR_PCR_BASE)) begin
			rdata_d[`DRTPR_PCR_IMPL_BIT] =
				DOMAIN_IMPL[dom_idx]; // [RULE16]
			rdata_d[`DRTPR_PCR_REQ_BIT] = dom_req[dom_idx]; // [RULE15]
		end else if (in_window(addr, `DRTPR_PSR_BASE)) begin
			rdata_d[1:0] = dom_state[2*dom_idx +: 2]; // [RULE18]
		end else if (addr == `DRTPR_FEAT_OFF) begin
			rdata_d[`DRTPR_FEAT_SYSTEM_RESET_REQ_PRESENT_BIT] = SYS_RESET_PRESENT; // [RULE1]
			rdata_d[`DRTPR_FEAT_DEBUG_RESET_REQ_PRESENT_BIT] = DBG_RESET_PRESENT; // [RULE2]
			rdata_d[3:0] = any_impl ? `DRTPR_FEAT_VER_V0 :
				`DRTPR_FEAT_VER_NONE; // [RULE3]
		end
	end
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			rdata <= 32'h00000000;
			pwr_req <= 32'h00000000;
		end else if (ce) begin
			rdata <= rd ? rdata_d : 32'h00000000;
			pwr_req <= dom_pwr;
		end
	end
endmodule

// ### drtpr_chk_sva.sv
// Port-level assertions for the debug directory and power request block
`timescale 1ns/100ps
module drtpr_chk #(
	parameter [31:0] DOMAIN_IMPL = 32'hffffffff
) (
	input wire clock,
	input wire rst,
	input wire [11:0] addr,
	input wire rd,
	input wire [31:0] rdata,
	input wire dbg_enable_pin,
	input wire [31:0] pwr_req
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// ============================================================
	// Properties
	property p_rd_idle;
		!$past(rd) |-> rdata == 32'h0;
	endproperty
	property p_entry0;
		rd && addr == 12'h000 |=> rdata == 32'h00001007;
	endproperty
	property p_entry1;
		rd && addr == 12'h004 |=> rdata == 32'hfffff017;
	endproperty
	property p_term;
		rd && addr == 12'h008 |=> rdata == 32'h0;
	endproperty
	property p_last;
		rd && addr == 12'h7fc |=> rdata == 32'h0;
	endproperty
	property p_feat;
		rd && addr == 12'hc00 |=> rdata == 32'h00000001;
	endproperty
	property p_pcr_impl;
		rd && addr[11:7] == 5'h16 |=>
			rdata[0] == DOMAIN_IMPL[$past(addr[6:2])] && rdata[31:2] == 30'h0;
	endproperty
	property p_psr_code;
		rd && addr[11:7] == 5'h17 |=> rdata[1:0] != 2'h2 && rdata[31:2] == 30'h0;
	endproperty
	property p_unimpl;
		rd && addr[11:8] == 4'hb && !DOMAIN_IMPL[addr[6:2]] |=> rdata == 32'h0;
	endproperty
	// Two sync flops, the domain request flop and the output register
	property p_dbg_off;
		!dbg_enable_pin [*5] |-> pwr_req == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("rdata not zero");
	a_entry0: assert property (p_entry0) else $error("entry 0 bad");
	a_entry1: assert property (p_entry1) else $error("entry 1 bad");
	a_term: assert property (p_term) else $error("terminator bad");
	a_last: assert property (p_last) else $error("last entry bad");
	a_feat: assert property (p_feat) else $error("feature bad");
	a_pcr_impl: assert property (p_pcr_impl) else $error("impl bit");
	a_psr_code: assert property (p_psr_code) else $error("bad state");
	a_unimpl: assert property (p_unimpl) else $error("unimpl read");
	a_dbg_off: assert property (p_dbg_off) else $error("req kept");
	c_held: cover property (rd && addr == 12'hb84 ##1 rdata == 32'h3);
	c_req: cover property ($rose(pwr_req[1]));
	c_drop: cover property ($fell(pwr_req[1]));
endmodule
bind drtpr_top drtpr_chk #(.DOMAIN_IMPL(DOMAIN_IMPL)) u_chk (.clock(clock),
	.rst(rst), .addr(addr), .rd(rd), .rdata(rdata),
	.dbg_enable_pin(dbg_enable_pin), .pwr_req(pwr_req));

// ### drtpr_pwr_model.sv
// Power controller model: a live domain reports power after a lag
`timescale 1ns/100ps
module drtpr_pwr_model (
	input wire clock,
	input wire rst,
	input wire [31:0] alive,
	input wire [31:0] req,
	output reg [31:0] pwr_ok
);
	reg [31:0] lag_q;
	// Dead domains never come up, so their state must stay off
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			lag_q <= 32'h0;
			pwr_ok <= 32'h0;
		end else begin
			// Power comes up only where it is asked for
			lag_q <= alive & req;
			pwr_ok <= lag_q;
		end
	end
endmodule

// ### tb_top.sv
// Self-checking bench for the debug directory and power request block
`timescale 1ns/100ps
module tb_top;
	reg clock = 1'b0;
	reg rst = 1'b1;
	reg [11:0] addr = 12'h0;
	reg [31:0] wdata = 32'h0;
	reg wr = 1'b0;
	reg rd = 1'b0;
	reg ce = 1'b1;
	reg dbg_en = 1'b1;
	reg [31:0] alive = 32'hfffffffb;
	wire [31:0] rdata;
	wire [31:0] pwr_req;
	wire [31:0] pwr_ok;
	integer fails = 0;
	integer n_checks = 0;
	integer i;
	reg [31:0] seen;
	reg [43:0] rows [0:8];
	always #5 clock = ~clock;
	drtpr_top #(.DOMAIN_IMPL(32'h7fffffff)) u_dut (.clock(clock), .rst(rst),
		.ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .pwr_ok_pin(pwr_ok), .dbg_enable_pin(dbg_en),
		.pwr_req(pwr_req));
	drtpr_pwr_model u_pwr (.clock(clock), .rst(rst), .alive(alive),
		.req(pwr_req), .pwr_ok(pwr_ok));
	// ============================================================
	// Tasks
	task stop_test;
		begin
			$display("checks %0d mismatches %0d", n_checks, fails);
			if (fails == 0 && n_checks > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	task check(input [31:0] got, input [31:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				fails = fails + 1;
				$display("FAIL %0t got %h want %h", $time, got, exp);
			end
		end
	endtask
	task wr_reg(input [11:0] a, input [31:0] d);
		begin
			@(posedge clock);
			wr <= 1'b1;
			addr <= a;
			wdata <= d;
			@(posedge clock);
			wr <= 1'b0;
		end
	endtask
	task rd_reg(input [11:0] a);
		begin
			@(posedge clock);
			rd <= 1'b1;
			addr <= a;
			@(posedge clock);
			rd <= 1'b0;
			#1 seen = rdata;
		end
	endtask
	task poll(input [11:0] a, input [31:0] e);
		integer k;
		begin
			k = 0;
			rd_reg(a);
			while (seen !== e && k < 20) begin
				rd_reg(a);
				k = k + 1;
			end
			check(seen, e);
			if (seen !== e)
				stop_test;
		end
	endtask
	// ============================================================
	// Sequence
	initial begin
		rows[0] = {12'h000, 32'h00001007};
		rows[1] = {12'h004, 32'hfffff017};
		rows[2] = {12'h008, 32'h0};
		rows[3] = {12'h7fc, 32'h0};
		rows[4] = {12'hc00, 32'h00000001};
		rows[5] = {12'hb00, 32'h00000001};
		rows[6] = {12'hb7c, 32'h0};
		rows[7] = {12'hb80, 32'h0};
		rows[8] = {12'hd00, 32'h0};
		repeat (6) @(posedge clock);
		#1 check(rdata, 32'h0);
		check(pwr_req, 32'h0);
		rst <= 1'b0;
		wr_reg(12'h000, 32'h0);
		for (i = 0; i < 9; i = i + 1) begin
			rd_reg(rows[i][43:32]);
			check(seen, rows[i][31:0]);
		end
		wr_reg(12'hb04, 32'h2);
		poll(12'hb84, 32'h3);
		check(pwr_req, 32'h2);
		rd_reg(12'hb04);
		check(seen, 32'h3);
		wr_reg(12'hb04, 32'h0);
		// Next request only once the old one has settled
		poll(12'hb84, 32'h0);
		check(pwr_req, 32'h0);
		wr_reg(12'hb08, 32'h2);
		repeat (10) @(posedge clock);
		rd_reg(12'hb88);
		check(seen, 32'h0);
		wr_reg(12'hb08, 32'h0);
		wr_reg(12'hb7c, 32'h2);
		rd_reg(12'hb7c);
		check(seen, 32'h0);
		rd_reg(12'hbfc);
		check(seen, 32'h0);
		// Frozen block ignores a write
		@(posedge clock);
		ce <= 1'b0;
		wr_reg(12'hb10, 32'h2);
		ce <= 1'b1;
		rd_reg(12'hb10);
		check(seen, 32'h1);
		// Mid-run reset withdraws a standing request
		wr_reg(12'hb04, 32'h2);
		poll(12'hb84, 32'h3);
		rst <= 1'b1;
		@(posedge clock);
		rst <= 1'b0;
		check(pwr_req, 32'h0);
		rd_reg(12'hb04);
		check(seen, 32'h1);
		rd_reg(12'hb84);
		check(seen, 32'h0);
		@(posedge clock);
		dbg_en <= 1'b0;
		repeat (5) @(posedge clock);
		wr_reg(12'hb0c, 32'h2);
		repeat (6) @(posedge clock);
		rd_reg(12'hb8c);
		check(seen, 32'h0);
		check(pwr_req, 32'h0);
		wr_reg(12'hb0c, 32'h0);
		stop_test;
	end
endmodule
